/* File: verilog/cst_pkg.sv */
// Constants and types for the core storage timing control unit
// Notes on behaviour
// - Address bits 16 and 29 pick one of four sense/inhibit section pairs.
// - Read clears every addressed bit; only former ones give a sense pulse.
// - Four sense amps per bit ORed to a detector, strobed into a sense latch.
// - During write, a zero data bit raises its inhibit driver.
// - Each data bit feeds four inhibit drivers; only the addressed one fires.
// - Only address bits 15 to 29 reach storage; bit 30 is not sent.
// - In 128K setups bit 15 chooses units 1 and 2 or units 3 and 4.
// - Read request starts every unit; bit 15 later gates drive currents.
// - Extension access sets a latch blocking normal Y, enabling extension Y.
// - Write data: 18 lines per unit, bytes 0-1 and bytes 2-3, chained on.
// - Read data: 18 lines per unit from sense latches, chained partners.
// - Each unit runs its own timing chain, started by read or write request.
// - Timing chain spans 500 ns, tapped every 25 ns, taps steer latches.
// - Pulse-width latch launches a 100 ns pulse into the chain at start.
// - Read-set governs read-1, read-2, X/Y read sources and strobe latches.
// - Write request starts all clocks; write-set only in units chosen by 15.
// - Write-set governs write, X/Y write source and inhibit latches.
// - System reset clears set latches and runs one chain pulse to clear rest.
// - Bytes 0-1 go to first address, bytes 2-3 to second address.
package cst_pkg;

    // Clock and chain timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int TAP_NS        = 25;
    localparam int CHAIN_NS      = 500;
    localparam int PULSE_NS      = 100;
    localparam int CHAIN_CYC     = (CHAIN_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
    localparam int PULSE_CYC     = (PULSE_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
    localparam int CNT_W         = 7;
    localparam int TAP_W         = 5;
    localparam logic [9:0] CLK_NS10 = 10'(CLK_PERIOD_NS);
    localparam logic [9:0] TAP_NS10 = 10'(TAP_NS);

    // Default tap positions, in 25 ns units; strobe delay in clock cycles
    localparam int TAP_ADDR  = 2;
    localparam int TAP_RD1_S = 3;
    localparam int TAP_RD1_C = 12;
    localparam int TAP_RD2_S = 3;
    localparam int TAP_RD2_C = 12;
    localparam int TAP_XSR_S = 4;
    localparam int TAP_XSR_C = 12;
    localparam int TAP_YSR_S = 4;
    localparam int TAP_YSR_C = 12;
    localparam int TAP_STB_S = 8;
    localparam int TAP_STB_C = 9;
    localparam int TAP_WR_S  = 3;
    localparam int TAP_WR_C  = 13;
    localparam int TAP_XSW_S = 4;
    localparam int TAP_XSW_C = 13;
    localparam int TAP_YSW_S = 4;
    localparam int TAP_YSW_C = 13;
    localparam int TAP_INH_S = 3;
    localparam int TAP_INH_C = 14;
    localparam int STB_DLY   = 2;

    // Address bit positions on the fifteen address lines
    localparam int ADR_FIRST = 15;
    localparam int ADR_LAST  = 29;
    localparam int ADR_UNIT  = 15;
    localparam int ADR_HALF  = 16;
    localparam int ADR_XGRP  = 29;

    // Data layout: two bytes with parity per unit, four sense amps per bit
    localparam int HW_BITS   = 18;
    localparam int SECTIONS  = 4;

    // Register port
    localparam int RA_W = 4;
    localparam int RD_W = 32;
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_SENSE  = 4'h8;
    localparam int CTRL_128K  = 0;
    localparam int CTRL_UPPER = 1;
    localparam int ST_TAP     = 0;
    localparam int ST_RUN     = 5;
    localparam int ST_RDSET   = 6;
    localparam int ST_WRSET   = 7;
    localparam int ST_SEL     = 8;
    localparam int ST_EXT     = 9;
    localparam int ST_ERR     = 10;

    typedef enum logic [0:0] {
        CH_IDLE = 1'h0,
        CH_RUN  = 1'h1
    } cst_chain_t;

endpackage

/* File: verilog/cst_unit.sv */
// Timing chain, latch sequence and section gating for one storage unit
`timescale 1ns/1ps
module cst_unit #(
    parameter int TAP_ADDR  = cst_pkg::TAP_ADDR,
    parameter int TAP_RD1_S = cst_pkg::TAP_RD1_S,
    parameter int TAP_RD1_C = cst_pkg::TAP_RD1_C,
    parameter int TAP_RD2_S = cst_pkg::TAP_RD2_S,
    parameter int TAP_RD2_C = cst_pkg::TAP_RD2_C,
    parameter int TAP_XSR_S = cst_pkg::TAP_XSR_S,
    parameter int TAP_XSR_C = cst_pkg::TAP_XSR_C,
    parameter int TAP_YSR_S = cst_pkg::TAP_YSR_S,
    parameter int TAP_YSR_C = cst_pkg::TAP_YSR_C,
    parameter int TAP_STB_S = cst_pkg::TAP_STB_S,
    parameter int TAP_STB_C = cst_pkg::TAP_STB_C,
    parameter int TAP_WR_S  = cst_pkg::TAP_WR_S,
    parameter int TAP_WR_C  = cst_pkg::TAP_WR_C,
    parameter int TAP_XSW_S = cst_pkg::TAP_XSW_S,
    parameter int TAP_XSW_C = cst_pkg::TAP_XSW_C,
    parameter int TAP_YSW_S = cst_pkg::TAP_YSW_S,
    parameter int TAP_YSW_C = cst_pkg::TAP_YSW_C,
    parameter int TAP_INH_S = cst_pkg::TAP_INH_S,
    parameter int TAP_INH_C = cst_pkg::TAP_INH_C,
    parameter int STB_DLY   = cst_pkg::STB_DLY
) (
    // Clock, reset, enable
    input  wire logic                  clk,
    input  wire logic                  nrst,
    input  wire logic                  clk_en,
    // Register port
    input  wire logic [cst_pkg::RA_W-1:0] reg_addr,
    input  wire logic [cst_pkg::RD_W-1:0] reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic [cst_pkg::RD_W-1:0]   reg_rdata,
    // Processor side of the storage interface
    input  wire logic                  read_call,
    input  wire logic                  write_call,
    input  wire logic                  sys_reset,
    input  wire logic [15:29]          storage_address_reg,
    input  wire logic                  use_ext,
    input  wire logic [17:0]           wdata,
    output logic [17:0]                rdata,
    // Partner unit chaining
    input  wire logic [17:0]           rdata_chain,
    output logic [17:0]                wdata_chain,
    // Sense amplifiers, index bit*4 + section
    input  wire logic [71:0]           sense_amp,
    output logic [3:0]                 sa_gate,
    output logic                       sense_strobe,
    // Drivers
    output logic [71:0]                inh_drv,
    output logic [1:0]                 x_ctrl_rd,
    output logic                       y_ctrl_rd,
    output logic                       x_src_rd,
    output logic                       y_src_rd,
    output logic [1:0]                 x_ctrl_wr,
    output logic                       y_ctrl_wr,
    output logic                       x_src_wr,
    output logic                       y_src_wr,
    output logic                       y_norm_blk,
    output logic                       y_ext_en,
    output logic                       pulse_width
);

    localparam int W = cst_pkg::TAP_W;
    localparam int N = cst_pkg::HW_BITS;
    localparam int S = cst_pkg::SECTIONS;
    localparam logic [cst_pkg::CNT_W-1:0] CNT_END =
        cst_pkg::CNT_W'(cst_pkg::CHAIN_CYC - 1);
    localparam logic [cst_pkg::CNT_W-1:0] CNT_PW =
        cst_pkg::CNT_W'(cst_pkg::PULSE_CYC);
    localparam int A_CHAIN = cst_pkg::CHAIN_CYC;

    // Tap reached by the pulse front after c cycles
    function automatic logic [W-1:0] tap_of(
        input logic [cst_pkg::CNT_W-1:0] c);
        logic [9:0] p;
        p = {3'h0, c} * cst_pkg::CLK_NS10;
        return W'(p / cst_pkg::TAP_NS10);
    endfunction

    // Timing latch: set at one tap while governed, cleared at another
    function automatic logic lat(input logic q, input logic run_i,
                                 input logic gov, input logic [W-1:0] t,
                                 input int s, input int c);
        logic r;
        r = q;
        if (!run_i) begin
            r = 1'b0;
        end else if (t == W'(c)) begin
            r = 1'b0;
        end else if (gov && t == W'(s)) begin
            r = 1'b1;
        end
        return r;
    endfunction

    // Section index from bits 16 and 29
    function automatic logic [1:0] sect(input logic b16, input logic b29);
        return {b16, ~b29};
    endfunction

    // One of two 8K halves from bit 16
    function automatic logic [1:0] half(input logic b16);
        return b16 ? 2'h2 : 2'h1;
    endfunction

    cst_pkg::cst_chain_t           chain;
    logic [cst_pkg::CNT_W-1:0]     cnt;
    logic [W-1:0]                  tap;
    logic                          run;
    logic                          start;
    logic                          rd_set;
    logic                          wr_set;
    logic                          rd1;
    logic                          rd2;
    logic                          xsr;
    logic                          ysr;
    logic                          stb;
    logic                          wr;
    logic                          xsw;
    logic                          ysw;
    logic                          inh;
    logic [STB_DLY:0]              stb_pipe;
    logic [15:29]                  adr_q;
    logic                          ext_q;
    logic                          sel_q;
    logic                          cfg_128k;
    logic                          cfg_upper;
    logic                          err;
    logic [N-1:0]                  det;
    logic [N-1:0]                  sense_q;
    logic [1:0]                    sec;
    logic                          live_sel;
    logic [cst_pkg::RD_W-1:0]      next_rdata;

    assign run   = (chain == cst_pkg::CH_RUN);
    assign tap   = tap_of(cnt);
    assign start = (read_call | write_call | sys_reset) & ~run;
    assign sec   = sect(adr_q[cst_pkg::ADR_HALF], adr_q[cst_pkg::ADR_XGRP]);
    // Unit choice follows bit 15 only in the four-unit setup
    assign live_sel = ~cfg_128k
        | (storage_address_reg[cst_pkg::ADR_UNIT] == cfg_upper);

    // Chain runs on its own, whatever the processor does meanwhile
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            chain <= cst_pkg::CH_IDLE;
            cnt   <= '0;
        end else if (clk_en) begin
            case (chain)
                cst_pkg::CH_IDLE: begin
                    if (start) begin
                        chain <= cst_pkg::CH_RUN;
                        cnt   <= '0;
                    end
                end
                cst_pkg::CH_RUN: begin
                    if (cnt == CNT_END) begin
                        chain <= cst_pkg::CH_IDLE;
                        cnt   <= '0;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                default: begin
                    chain <= cst_pkg::CH_IDLE;
                end
            endcase
        end
    end

    // Launch pulse, 100 ns long from the first chain cycle
    assign pulse_width = run && (cnt < CNT_PW);

    // Set latches; system reset wins and still launches a chain pulse
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_set <= 1'b0;
            wr_set <= 1'b0;
        end else if (clk_en) begin
            if (sys_reset) begin
                rd_set <= 1'b0;
                wr_set <= 1'b0;
            end else if (start && read_call) begin
                rd_set <= 1'b1;
            end else if (start && write_call) begin
                wr_set <= live_sel;
            end else if (run && cnt == CNT_END) begin
                rd_set <= 1'b0;
                wr_set <= 1'b0;
            end
        end
    end

    // Address taken late in read, at once on write
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            adr_q <= '0;
            ext_q <= 1'b0;
            sel_q <= 1'b0;
        end else if (clk_en) begin
            if ((start && write_call && !sys_reset)
                || (run && rd_set && tap == W'(TAP_ADDR))) begin
                adr_q <= storage_address_reg;
                ext_q <= use_ext;
                sel_q <= live_sel;
            end else if (sys_reset || (run && cnt == CNT_END)) begin
                ext_q <= 1'b0;
            end
        end
    end

    // Read timing latches
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd1 <= 1'b0;
            rd2 <= 1'b0;
            xsr <= 1'b0;
            ysr <= 1'b0;
            stb <= 1'b0;
        end else if (clk_en) begin
            rd1 <= lat(rd1, run, rd_set, tap, TAP_RD1_S, TAP_RD1_C);
            rd2 <= lat(rd2, run, rd_set, tap, TAP_RD2_S, TAP_RD2_C);
            xsr <= lat(xsr, run, rd_set, tap, TAP_XSR_S, TAP_XSR_C);
            ysr <= lat(ysr, run, rd_set, tap, TAP_YSR_S, TAP_YSR_C);
            stb <= lat(stb, run, rd_set & rd1, tap,
                       TAP_STB_S, TAP_STB_C);
        end
    end

    // Write timing latches
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr  <= 1'b0;
            xsw <= 1'b0;
            ysw <= 1'b0;
            inh <= 1'b0;
        end else if (clk_en) begin
            wr  <= lat(wr, run, wr_set, tap, TAP_WR_S, TAP_WR_C);
            xsw <= lat(xsw, run, wr_set, tap, TAP_XSW_S, TAP_XSW_C);
            ysw <= lat(ysw, run, wr_set, tap, TAP_YSW_S, TAP_YSW_C);
            inh <= lat(inh, run, wr_set, tap, TAP_INH_S, TAP_INH_C);
        end
    end

    // Strobe latch through a further delay, edge gives one-cycle strobe
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stb_pipe <= '0;
        end else if (clk_en) begin
            stb_pipe <= {stb_pipe[STB_DLY-1:0], stb};
        end
    end
    assign sense_strobe = stb_pipe[STB_DLY-1] & ~stb_pipe[STB_DLY];

    // Only the addressed section of the addressed unit listens
    assign sa_gate = (rd_set && sel_q) ? (4'h1 << sec) : 4'h0;

    always_comb begin
        for (int i = 0; i < N; i++) begin
            det[i] = |(sense_amp[i*S +: S] & sa_gate);
        end
    end

    // Cleared at read start so untouched zeros read back as zero
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sense_q <= '0;
        end else if (clk_en) begin
            if (start && read_call && !sys_reset) begin
                sense_q <= '0;
            end else if (sense_strobe) begin
                sense_q <= sense_q | det;
            end
        end
    end

    // Halfword out from own sense latches, else passed from partner
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata       <= '0;
            wdata_chain <= '0;
        end else if (clk_en) begin
            rdata       <= sel_q ? sense_q : rdata_chain;
            wdata_chain <= wdata;
        end
    end

    // Inhibit raised only for zero bits, only in the addressed section
    always_comb begin
        inh_drv = '0;
        for (int i = 0; i < N; i++) begin
            if (inh && sel_q && !wdata[i]) begin
                inh_drv[i*S + 32'(sec)] = 1'b1;
            end
        end
    end

    // Drivers; this unit writes its halfword to its own address lines
    assign x_ctrl_rd = (rd1 && sel_q) ? half(adr_q[cst_pkg::ADR_HALF])
                                      : 2'h0;
    assign y_ctrl_rd = rd2 && sel_q;
    assign x_src_rd  = xsr && sel_q;
    assign y_src_rd  = ysr && sel_q;
    assign x_ctrl_wr = wr ? half(adr_q[cst_pkg::ADR_HALF]) : 2'h0;
    assign y_ctrl_wr = wr;
    assign x_src_wr  = xsw;
    assign y_src_wr  = ysw;
    assign y_norm_blk = ext_q;
    assign y_ext_en   = ext_q && (y_ctrl_rd || y_ctrl_wr);

    // Control register and overlap flag; a new overlap beats the clear
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cfg_128k  <= 1'b0;
            cfg_upper <= 1'b0;
            err       <= 1'b0;
        end else if (clk_en) begin
            if (reg_wr && reg_addr == cst_pkg::REG_CTRL) begin
                cfg_128k  <= reg_wdata[cst_pkg::CTRL_128K];
                cfg_upper <= reg_wdata[cst_pkg::CTRL_UPPER];
            end
            if (run && (read_call || write_call)) begin
                err <= 1'b1;
            end else if (reg_wr && reg_addr == cst_pkg::REG_STATUS
                         && reg_wdata[cst_pkg::ST_ERR]) begin
                err <= 1'b0;
            end
        end
    end

    always_comb begin
        next_rdata = '0;
        if (reg_addr == cst_pkg::REG_CTRL) begin
            next_rdata[cst_pkg::CTRL_128K]  = cfg_128k;
            next_rdata[cst_pkg::CTRL_UPPER] = cfg_upper;
        end else if (reg_addr == cst_pkg::REG_STATUS) begin
            next_rdata[cst_pkg::ST_TAP +: W] = tap;
            next_rdata[cst_pkg::ST_RUN]   = run;
            next_rdata[cst_pkg::ST_RDSET] = rd_set;
            next_rdata[cst_pkg::ST_WRSET] = wr_set;
            next_rdata[cst_pkg::ST_SEL]   = sel_q;
            next_rdata[cst_pkg::ST_EXT]   = ext_q;
            next_rdata[cst_pkg::ST_ERR]   = err;
        end else if (reg_addr == cst_pkg::REG_SENSE) begin
            next_rdata[N-1:0] = sense_q;
        end
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= '0;
        end else if (clk_en) begin
            reg_rdata <= reg_rd ? next_rdata : '0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst || !clk_en);

    a_section_gate: assert property (
        rd_set && sel_q |-> sa_gate == (4'h1 << {adr_q[16], ~adr_q[29]}))
        else $error("sense gate does not match bits 16 and 29");

    a_inhibit_zero: assert property (
        (|inh_drv) |-> inh && sel_q)
        else $error("inhibit driven outside inhibit latch");

    a_inhibit_one: assert property (
        inh && sel_q |-> inh_drv[32'(sec)] == ~wdata[0]
            && $countones(inh_drv[S-1:0]) <= 1)
        else $error("inhibit driver for bit 0 wrong");

    a_pulse_width: assert property (
        $rose(run) |-> pulse_width [*8])
        else $error("launch pulse too short");

    a_chain_span: assert property (
        $rose(run) |-> ##(A_CHAIN) !run)
        else $error("timing chain did not end at 500 ns");

    a_read_starts: assert property (
        read_call && !run && !sys_reset |=> rd_set && run)
        else $error("read call did not start the unit");

    a_write_sel: assert property (
        write_call && !run && !sys_reset |=> run && wr_set == $past(live_sel))
        else $error("write set not gated by unit select");

    a_reset_clear: assert property (
        sys_reset && !run |=> run && !rd_set && !wr_set ##(A_CHAIN) !run
            && !rd1 && !wr && !inh)
        else $error("system reset cycle did not clear latches");

    a_sense_take: assert property (
        sense_strobe |=> (sense_q & $past(det)) == $past(det))
        else $error("strobed detector not latched");

    a_ext_block: assert property (
        y_ext_en |-> y_norm_blk)
        else $error("extension Y without normal Y blocked");

    c_read_cycle:  cover property (rd_set && sense_strobe);
    c_write_cycle: cover property (wr_set && (|inh_drv));
    c_reset_run:   cover property (sys_reset && !run ##1 run);
    c_ext_access:  cover property (y_ext_en);

endmodule

/* File: dv/cst_proc_model.sv */
// Processor-side model that issues storage read and write calls
`timescale 1ns/1ps
module cst_proc_model (
    // Clock
    input  wire logic    clk,
    // Storage requests
    output logic         read_call,
    output logic         write_call,
    // Bit 14 never leaves the processor
    output logic [15:29] addr,
    output logic         ext,
    output logic [17:0]  wdata
);
    initial begin
        read_call  = 1'b0;
        write_call = 1'b0;
        addr       = 15'h0;
        ext        = 1'b0;
        wdata      = 18'h0;
    end

    // Address loads with the call, so it is valid when the call is seen
    task automatic start_read(input logic [15:29] a, input logic e);
        read_call <= 1'b1;
        addr      <= a;
        ext       <= e;
        @(posedge clk);
        read_call <= 1'b0;
    endtask

    // Caller follows each read in the rw task with this
    task automatic start_write(input logic [17:0] d);
        write_call <= 1'b1;
        wdata      <= d;
        @(posedge clk);
        write_call <= 1'b0;
    endtask
endmodule

/* File: dv/testbench.sv */
// Self-checking bench for the storage timing control unit
`timescale 1ns/1ps
module testbench;
    localparam logic [17:0] CHAIN = 18'h2C3A5;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        sys_reset = 1'b0;
    logic [71:0] sense_amp = 72'h0;
    logic [31:0] reg_rdata;
    logic        read_call, write_call, use_ext, y_norm_blk, pulse_width;
    logic [15:29] addr;
    logic [17:0] wdata, rdata, wdata_chain;
    logic [3:0]  sa_gate, s_sa;
    logic [1:0]  x_ctrl_rd, s_x;
    logic [1:0]  x_ctrl_wr, s_xw;
    logic        s_y, y_ext_en, s_ye;
    logic [71:0] inh_drv, s_inh;
    int          fail_count = 0;
    int          cmp_count = 0;

    always #4 clk = ~clk;

    cst_unit u_dut (
        .clk(clk), .nrst(nrst), .clk_en(1'b1),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .read_call(read_call), .write_call(write_call),
        .sys_reset(sys_reset), .storage_address_reg(addr),
        .use_ext(use_ext), .wdata(wdata), .rdata(rdata),
        .rdata_chain(CHAIN), .wdata_chain(wdata_chain),
        .sense_amp(sense_amp), .sa_gate(sa_gate), .sense_strobe(),
        .inh_drv(inh_drv), .x_ctrl_rd(x_ctrl_rd), .y_ctrl_rd(),
        .x_src_rd(), .y_src_rd(), .x_ctrl_wr(x_ctrl_wr), .y_ctrl_wr(),
        .x_src_wr(), .y_src_wr(), .y_norm_blk(y_norm_blk),
        .y_ext_en(y_ext_en), .pulse_width(pulse_width)
    );

    cst_proc_model u_proc (
        .clk(clk), .read_call(read_call), .write_call(write_call),
        .addr(addr), .ext(use_ext), .wdata(wdata)
    );

    task automatic complete_run();
        $display("Compares %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [71:0] got, input logic [71:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rg_w(input logic [3:0] a, input logic [31:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
        @(posedge clk);
    endtask

    // Data stands only in the cycle after the strobe
    task automatic rg_r(input logic [3:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
        @(posedge clk);
    endtask

    // Entered in the chain's first cycle, so the whole launch pulse counts
    task automatic run_span(output int pw);
        pw = 0;
        for (int k = 0; k < 68; k++) begin
            #1;
            if (k == 18) begin
                s_sa  = sa_gate;
                s_x   = x_ctrl_rd;
                s_xw  = x_ctrl_wr;
                s_y   = y_norm_blk;
                s_ye  = y_ext_en;
                s_inh = inh_drv;
            end
            pw += pulse_width;
            @(posedge clk);
        end
    endtask

    // Read then write one section; other sections carry the inverse
    task automatic rw(input logic [1:0] s, input logic b15, e, sel);
        logic [17:0] p;
        logic [17:0] w;
        logic [71:0] sa;
        logic [71:0] ei;
        int          pw;
        p  = 18'h15A3C ^ {16'h0, s};
        w  = ~p;
        ei = 72'h0;
        for (int i = 0; i < 18; i++) begin
            for (int j = 0; j < 4; j++)
                sa[i*4+j] = (j == s) ? p[i] : ~p[i];
            ei[i*4+s] = sel & p[i];
        end
        sense_amp <= sa;
        u_proc.start_read({b15, s[1], 12'h5A5, ~s[0]}, e);
        run_span(pw);
        chk(s_sa, sel ? (4'h1 << s) : 4'h0);
        chk(s_x, sel ? (2'h1 << s[1]) : 2'h0);
        chk(s_y, e);
        chk(s_ye, e & sel);
        chk(pw, 13);
        chk(rdata, sel ? p : CHAIN);
        u_proc.start_write(w);
        run_span(pw);
        chk(s_inh, ei);
        chk(s_xw, sel ? (2'h1 << s[1]) : 2'h0);
        chk(wdata_chain, w);
    endtask

    initial begin
        #50000;
        fail_count++;
        complete_run();
    end

    initial begin
        logic [31:0] d;
        int          pw;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rg_r(4'h4, d);
        chk(d, 32'h0);
        rg_r(4'hC, d);
        chk(d, 32'h0);
        for (int s = 0; s < 4; s++)
            rw(2'(s), 1'b0, s == 3, 1'b1);
        rg_w(4'h0, 32'h1);
        rw(2'h1, 1'b1, 1'b0, 1'b0);
        rw(2'h2, 1'b0, 1'b0, 1'b1);
        rg_w(4'h0, 32'h3);
        rw(2'h0, 1'b1, 1'b0, 1'b1);
        // Second call while running is refused and flagged
        u_proc.start_read(15'h0, 1'b0);
        @(posedge clk);
        u_proc.start_read(15'h0, 1'b0);
        rg_r(4'h4, d);
        chk(d[10], 1'b1);
        rg_w(4'h4, 32'h400);
        run_span(pw);
        rg_r(4'h4, d);
        chk({d[10], d[7:5]}, 4'h0);
        u_proc.start_write(18'h0);
        run_span(pw);
        // System reset mid-read, then again while idle
        u_proc.start_read(15'h0, 1'b0);
        sys_reset <= 1'b1;
        @(posedge clk);
        sys_reset <= 1'b0;
        rg_r(4'h4, d);
        chk(d[7:5], 3'h1);
        run_span(pw);
        sys_reset <= 1'b1;
        @(posedge clk);
        sys_reset <= 1'b0;
        run_span(pw);
        chk(pw, 13);
        complete_run();
    end
endmodule
